// *** rtl/lcp_top.sv ***
// Purpose: control and polarity stage of a configurable logic cell with APB registers
// Assumes: sel_data arrives asynchronously; gate_cfg comes from logic on pclk
// Notes:   zero wait states; the flag register clears on a written one
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "lcp_consts.svh"
module lcp_top
    import lcp_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [3:0]    sel_data,
    input  lcp_gate_cfg_t      gate_cfg,
    output logic               cell_out,
    output logic               pin_out,
    output logic               pin_oe,
    output logic               edge_irq_flag
);

    lcp_ctrl_s   ctrl_r;
    lcp_ctrl_s   ctrl_nxt;
    lcp_pol_s    pol_r;
    lcp_pol_s    pol_nxt;
    logic [3:0]  sync1_r;
    logic [3:0]  sync2_r;
    logic [3:0]  gate_raw;
    logic [3:0]  gate_eff;
    logic        func_res;
    logic        out_r;
    logic        out_nxt;
    logic        prev_r;
    logic        flag_r;
    logic        flag_nxt;
    logic        rise;
    logic        fall;
    logic        setup;
    logic        access;
    logic        wr;
    logic        hit_ctrl;
    logic        hit_pol;
    logic        hit_flag;
    logic        flag_clr;
    logic [7:0]  rd_byte;
    logic        pready_r;
    logic        pready_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // data gate: AND of enabled terms, zero with no term enabled
    function automatic logic gate_and(input logic [7:0] sel, input logic [3:0] d);
        logic acc;
        acc = |sel;
        for (int k = 0; k < 4; k++) begin
            if (sel[2*k+1] && !d[k]) acc = 1'b0;
            if (sel[2*k] && d[k]) acc = 1'b0;
        end
        return acc;
    endfunction : gate_and

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
        end else begin
            sync1_r <= sel_data;
            sync2_r <= sync1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    assign setup    = psel & ~penable;
    assign access   = psel & penable & pready_r;
    assign wr       = access & pwrite;
    assign hit_ctrl = (paddr == `LCP_ADDR_CTRL);
    assign hit_pol  = (paddr == `LCP_ADDR_POL);
    assign hit_flag = (paddr == `LCP_ADDR_FLAG);
    assign flag_clr = wr & hit_flag & pwdata[`LCP_FLAG_BIT];

    always_comb begin
        rd_byte = 8'h00;
        if (hit_ctrl) begin
            rd_byte = ctrl_r;
            rd_byte[`LCP_CTRL_OUT_BIT] = out_r;
        end else if (hit_pol) begin
            rd_byte = pol_r & ~`LCP_POL_RSV_MASK;
        end else if (hit_flag) begin
            rd_byte[`LCP_FLAG_BIT] = flag_r;
        end
    end

    always_comb begin
        pready_nxt  = setup;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (setup) begin
            pslverr_nxt = ~(hit_ctrl | hit_pol | hit_flag);
            prdata_nxt  = 32'h0000_0000;
            if (!pwrite) prdata_nxt = {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= pready_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    // write on access edge
    always_comb begin
        ctrl_nxt = ctrl_r;
        pol_nxt  = pol_r;
        if (wr && hit_ctrl) ctrl_nxt = lcp_ctrl_s'(pwdata[7:0] & `LCP_CTRL_WMASK);
        if (wr && hit_pol) pol_nxt = lcp_pol_s'(pwdata[7:0] & `LCP_POL_WMASK);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= lcp_ctrl_s'(`LCP_CTRL_RST);
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge pclk) begin
        pol_r <= pol_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // datapath; nothing here is gated by a sleep state
    // gate AND stage
    always_comb begin
        for (int g = 0; g < 4; g++) begin
            gate_raw[g] = gate_and(gate_cfg[g], sync2_r);
        end
    end

    assign gate_eff = gate_raw ^ pol_r.gate_invert;

    lcp_func u_func (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (ctrl_r.cell_enable),
        .mode    (ctrl_r.function_select),
        .gate    (gate_eff),
        .result  (func_res)
    );

    assign out_nxt = ctrl_r.cell_enable & (func_res ^ pol_r.output_invert);

    ////////////////////////////////////////////////////////////////////////////
    // edge detection and flag
    // compare with previous output
    assign rise = out_r & ~prev_r;
    assign fall = ~out_r & prev_r;

    always_comb begin
        flag_nxt = flag_r & ~flag_clr;
        if ((rise && ctrl_r.rise_irq_enable) || (fall && ctrl_r.fall_irq_enable)) flag_nxt = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_r  <= 1'b0;
            prev_r <= 1'b0;
            flag_r <= `LCP_FLAG_RST;
        end else begin
            out_r  <= out_nxt;
            prev_r <= out_r;
            flag_r <= flag_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    // pin drive follows enable
    assign pin_oe        = ctrl_r.pin_output_enable;
    assign pin_out       = out_r;
    assign cell_out      = out_r;
    assign edge_irq_flag = flag_r;
    assign prdata        = prdata_r;
    assign pready        = pready_r;
    assign pslverr       = pslverr_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wr(logic [7:0] a);
        psel && penable && pready && pwrite && paddr == a;
    endsequence

    sequence s_rd_setup(logic [7:0] a);
        psel && !penable && !pwrite && paddr == a;
    endsequence

    sequence s_unmapped_setup;
        psel && !penable && !(hit_ctrl || hit_pol || hit_flag);
    endsequence

    AST_DISABLED_ZERO: assert property (!ctrl_r.cell_enable |=> !cell_out)
        else $error("disabled cell output not zero");
    AST_PIN_OE_SET: assert property (s_wr(`LCP_ADDR_CTRL) ##0 pwdata[`LCP_CTRL_OE_BIT] |=> pin_oe)
        else $error("pin enable not set by write");
    AST_READBACK: assert property (s_rd_setup(`LCP_ADDR_CTRL) |=> prdata[`LCP_CTRL_OUT_BIT] == $past(out_r))
        else $error("read-back bit differs from output");
    AST_RISE_FLAG: assert property ($rose(out_r) && ctrl_r.rise_irq_enable |=> edge_irq_flag)
        else $error("enabled rising edge did not set flag");
    AST_FALL_FLAG: assert property ($fell(out_r) && ctrl_r.fall_irq_enable |=> edge_irq_flag)
        else $error("enabled falling edge did not set flag");
    AST_RISE_MASKED: assert property ($rose(out_r) && !ctrl_r.rise_irq_enable && !edge_irq_flag |=> !edge_irq_flag)
        else $error("masked rising edge set flag");
    AST_AND4: assert property (ctrl_r.cell_enable && ctrl_r.function_select == LCP_AND4 |=>
        out_r == ($past(&gate_eff) ^ $past(pol_r.output_invert)))
        else $error("four-input and result wrong");
    AST_OUT_INVERT: assert property (ctrl_r.cell_enable |=> out_r == ($past(func_res) ^ $past(pol_r.output_invert)))
        else $error("output inversion wrong");
    AST_POL_RSV_ZERO: assert property (s_rd_setup(`LCP_ADDR_POL) |=> prdata[6:4] == 3'b000)
        else $error("reserved polarity bits not zero");
    AST_SET_WINS: assert property (s_wr(`LCP_ADDR_FLAG) ##0 pwdata[`LCP_FLAG_BIT] && rise && ctrl_r.rise_irq_enable
        |=> edge_irq_flag)
        else $error("edge lost during flag clear");
    AST_FLAG_CLEAR: assert property (s_wr(`LCP_ADDR_FLAG) ##0 pwdata[`LCP_FLAG_BIT] && !rise && !fall
        |=> !edge_irq_flag)
        else $error("flag not cleared by write");
    AST_GATE_INV: assert property (pol_r.gate_invert[0] && $stable(sync2_r) && $stable(gate_cfg[0])
        |-> gate_eff[0] != gate_and(gate_cfg[0], sync2_r))
        else $error("gate 1 not inverted");
    AST_CTRL_WRITE: assert property (s_wr(`LCP_ADDR_CTRL) |=> ctrl_r.function_select == $past(pwdata[2:0]))
        else $error("control write not taken");

    AST_FALL_MASKED: assert property ($fell(out_r) && !ctrl_r.fall_irq_enable && !edge_irq_flag |=> !edge_irq_flag)
        else $error("masked falling edge set flag");
    AST_PIN_OE_CLEAR: assert property (s_wr(`LCP_ADDR_CTRL) ##0 !pwdata[`LCP_CTRL_OE_BIT] |=> !pin_oe)
        else $error("pin enable not cleared by write");
    AST_FLAG_HOLD: assert property (edge_irq_flag && !flag_clr |=> edge_irq_flag)
        else $error("flag dropped without a clear");
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
        else $error("access phase without ready");
    AST_UNMAPPED_ERR: assert property (s_unmapped_setup |=> pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not flagged");
    AST_MAPPED_OK: assert property (psel && !penable && (hit_ctrl || hit_pol || hit_flag) |=> !pslverr)
        else $error("mapped access flagged as error");

endmodule : lcp_top

// *** rtl/lcp_consts.svh ***
// Purpose: offsets, field positions, masks and reset values of the logic cell stage
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   definitions only
`ifndef LCP_CONSTS_SVH
`define LCP_CONSTS_SVH

// register byte addresses
`define LCP_ADDR_CTRL     8'h00
`define LCP_ADDR_POL      8'h04
`define LCP_ADDR_FLAG     8'h08

// control register fields
`define LCP_CTRL_EN_BIT   7
`define LCP_CTRL_OE_BIT   6
`define LCP_CTRL_OUT_BIT  5
`define LCP_CTRL_INTP_BIT 4
`define LCP_CTRL_INTN_BIT 3
`define LCP_CTRL_WMASK    8'hdf
`define LCP_CTRL_RST      8'h00

// polarity register fields
`define LCP_POL_OUTINV_BIT 7
`define LCP_POL_RSV_MASK   8'h70
`define LCP_POL_WMASK      8'h8f

// flag register fields
`define LCP_FLAG_BIT      0
`define LCP_FLAG_RST      1'b0

`endif

// *** rtl/lcp_pkg.sv ***
// Purpose: types shared by the logic cell stage
// Assumes: field layout as in lcp_consts.svh
// Notes:   control and polarity travel as packed bytes
package lcp_pkg;

    typedef enum logic [2:0] {
        LCP_AND_OR   = 3'b000,
        LCP_OR_XOR   = 3'b001,
        LCP_AND4     = 3'b010,
        LCP_SR_LATCH = 3'b011,
        LCP_DFF_SR   = 3'b100,
        LCP_DFF_R2   = 3'b101,
        LCP_JKFF_R   = 3'b110,
        LCP_LATCH_SR = 3'b111
    } lcp_mode_e;

    typedef struct packed {
        logic      cell_enable;
        logic      pin_output_enable;
        logic      cell_output_value;
        logic      rise_irq_enable;
        logic      fall_irq_enable;
        lcp_mode_e function_select;
    } lcp_ctrl_s;

    typedef struct packed {
        logic       output_invert;
        logic [2:0] unused;
        logic [3:0] gate_invert;
    } lcp_pol_s;

    // one byte per gate: bit 2k+1 takes data k true, bit 2k takes it inverted
    typedef logic [3:0][7:0] lcp_gate_cfg_t;

endpackage : lcp_pkg

// *** rtl/lcp_func.sv ***
// Purpose: eight-way logic function of the cell
// Assumes: gates already inverted as configured; state sampled on pclk
// Notes:   g1 is the clock input of the flip-flop modes; g3 reset, g4 set in LCP_DFF_SR and LCP_LATCH_SR
`timescale 1ns/100ps
module lcp_func
    import lcp_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  lcp_mode_e       mode,
    input  wire logic [3:0] gate,
    output logic            result
);

    logic state_r;
    logic state_nxt;
    logic clk_prev_r;
    logic clk_prev_nxt;
    logic g1;
    logic g2;
    logic g3;
    logic g4;
    logic clk_rise;

    assign {g4, g3, g2, g1} = gate;
    assign clk_rise = g1 & ~clk_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // storage modes
    always_comb begin
        state_nxt    = state_r;
        clk_prev_nxt = g1;
        if (!run) begin
            state_nxt = 1'b0;
        end else begin
            unique case (mode)
                LCP_AND_OR, LCP_OR_XOR, LCP_AND4: begin
                    state_nxt = 1'b0;
                end
                LCP_SR_LATCH: begin
                    if (g3 | g4) state_nxt = 1'b0;
                    else if (g1 | g2) state_nxt = 1'b1;
                end
                LCP_DFF_SR: begin
                    if (g3) state_nxt = 1'b0;
                    else if (g4) state_nxt = 1'b1;
                    else if (clk_rise) state_nxt = g2;
                end
                LCP_DFF_R2: begin
                    if (g3) state_nxt = 1'b0;
                    else if (clk_rise) state_nxt = g2 & g4;
                end
                LCP_JKFF_R: begin
                    if (g3) state_nxt = 1'b0;
                    else if (clk_rise && (g2 || g4)) state_nxt = g2 & (~g4 | ~state_r);
                end
                LCP_LATCH_SR: begin
                    if (g3) state_nxt = 1'b0;
                    else if (g4) state_nxt = 1'b1;
                    else if (g1) state_nxt = g2;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= 1'b0;
            clk_prev_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            clk_prev_r <= clk_prev_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // combinational modes
    always_comb begin
        unique case (mode)
            LCP_AND_OR: result = (g1 & g2) | (g3 & g4);
            LCP_OR_XOR: result = (g1 | g2) ^ (g3 | g4);
            LCP_AND4:   result = g1 & g2 & g3 & g4;
            LCP_SR_LATCH, LCP_DFF_SR, LCP_DFF_R2, LCP_JKFF_R, LCP_LATCH_SR: result = state_r;
        endcase
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_DFF_CAPTURE: assert property (run && mode == LCP_DFF_SR && !g3 && !g4 && clk_rise |=> state_r == $past(g2))
        else $error("d flip-flop did not capture data on clock rise");
    AST_JK_TOGGLE: assert property (run && mode == LCP_JKFF_R && !g3 && clk_rise && g2 && g4 |=> state_r != $past(state_r))
        else $error("j-k flip-flop did not toggle");

endmodule : lcp_func

// *** verif/lcp_top_tb.sv ***
// Purpose: self-checking bench for the logic cell control and polarity stage
// Assumes: zero-wait APB slave, 3-edge input path, sequential modes one pclk late
// Notes:   gates pass data k true into gate k+1; gate_cfg changes only in the gate test
`timescale 1ns/100ps
`include "lcp_consts.svh"
module lcp_top_tb
    import lcp_pkg::*;
;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic [3:0]    sel_data = 4'h0;
    lcp_gate_cfg_t gate_cfg = {8'h80, 8'h20, 8'h08, 8'h02};
    logic          cell_out;
    logic          pin_out;
    logic          pin_oe;
    logic          edge_irq_flag;
    logic [31:0]   rdat;
    logic          rerr;
    logic [3:0]    inv;
    logic          oi;
    logic          ex;
    int            error_cnt = 0;
    int            tests_run = 0;
    int            cyc = 0;
    // gate 1 config, sel_data, expected output
    logic [15:0]   gcfg_tab [4] = '{16'h6651, 16'h6670, 16'h6640, 16'h0050};
    // mode, sel_data, expected output
    logic [7:0]    seq_tab [32] = '{8'h84, 8'h87, 8'h83, 8'h81, 8'h82, 8'h91, 8'h88, 8'h63, 8'h61, 8'h68,
                                    8'h60, 8'h65, 8'h74, 8'hb4, 8'hb7, 8'hb5, 8'ha5, 8'ha6, 8'hc4, 8'hc7,
                                    8'hc1, 8'hd2, 8'hd0, 8'hd7, 8'hc8, 8'he7, 8'he2, 8'he4, 8'he7, 8'he5,
                                    8'he8, 8'hf1};

    always #4 pclk = ~pclk;

    lcp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                 .sel_data(sel_data), .gate_cfg(gate_cfg), .cell_out(cell_out), .pin_out(pin_out),
                 .pin_oe(pin_oe), .edge_irq_flag(edge_irq_flag));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            $display("ERROR t=%0t run hung", $time);
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n, 1, "wait states");
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp, "read data");
        chk(32'(rerr), 32'(err), "slave error");
    endtask : rd

    task automatic sel(input logic [3:0] d, input int n);
        @(posedge pclk);
        sel_data <= d;
        wt(n);
    endtask : sel

    function automatic logic fexp(input logic [2:0] m, input logic [3:0] g);
        case (m)
            3'b000:  return (g[0] & g[1]) | (g[2] & g[3]);
            3'b001:  return (g[0] | g[1]) ^ (g[2] | g[3]);
            default: return &g;
        endcase
    endfunction : fexp

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wt(12);
        presetn <= 1'b1;
        rd(`LCP_ADDR_CTRL, 32'h0, 1'b0);
        rd(`LCP_ADDR_FLAG, 32'h0, 1'b0);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h0, 1'b1);
        chk(pin_oe, 1'b0, "oe after reset");
        $display("test reset done");

        wr(`LCP_ADDR_POL, 32'h80);
        wr(`LCP_ADDR_CTRL, 32'h62);
        sel(4'hf, 4);
        chk(cell_out, 1'b0, "disabled out");
        chk(pin_oe, 1'b1, "oe set");
        rd(`LCP_ADDR_CTRL, 32'h42, 1'b0);
        wr(`LCP_ADDR_CTRL, 32'h02);
        wt(2);
        chk(pin_oe, 1'b0, "oe clear");
        $display("test disable done");

        for (int m = 0; m < 3; m++) begin
            wr(`LCP_ADDR_CTRL, {24'h0, 5'h18, 3'(m)});
            for (int d = 0; d < 16; d++) begin
                inv = 4'(d * 3 + m);
                oi  = inv[1] ^ d[0];
                sel(4'(d), 0);
                wr(`LCP_ADDR_POL, {24'h0, oi, 3'h7, inv});
                wt(4);
                ex = fexp(3'(m), 4'(d) ^ inv) ^ oi;
                chk(cell_out, ex, "comb out");
                chk(pin_out, ex, "pin out");
                rd(`LCP_ADDR_CTRL, {24'h0, 2'b11, ex, 2'b00, 3'(m)}, 1'b0);
                rd(`LCP_ADDR_POL, {24'h0, oi, 3'h0, inv}, 1'b0);
            end
        end
        $display("test combinational done");

        // gates 2-4 are empty and inverted to one, so the and4 result is gate 1 alone
        wr(`LCP_ADDR_POL, 32'h0e);
        wr(`LCP_ADDR_CTRL, 32'h82);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            gate_cfg <= {24'h00_0000, gcfg_tab[i][15:8]};
            sel(gcfg_tab[i][7:4], 5);
            chk(cell_out, gcfg_tab[i][0], "gate and");
        end
        @(posedge pclk);
        gate_cfg <= {8'h80, 8'h20, 8'h08, 8'h02};
        $display("test gate done");

        wr(`LCP_ADDR_POL, 32'h0);
        for (int i = 0; i < 32; i++) begin
            if (i == 0 || seq_tab[i][7:5] != seq_tab[i-1][7:5]) begin
                wr(`LCP_ADDR_CTRL, 32'h0);
                sel(4'h0, 5);
                wr(`LCP_ADDR_CTRL, {24'h0, 5'h10, seq_tab[i][7:5]});
                wt(5);
            end
            sel(seq_tab[i][4:1], 5);
            chk(cell_out, seq_tab[i][0], "seq out");
        end
        $display("test sequential done");

        wr(`LCP_ADDR_CTRL, 32'h92);
        sel(4'h0, 5);
        wr(`LCP_ADDR_FLAG, 32'h1);
        sel(4'hf, 5);
        chk(edge_irq_flag, 1'b1, "rise flag");
        rd(`LCP_ADDR_FLAG, 32'h1, 1'b0);
        wr(`LCP_ADDR_FLAG, 32'h1);
        rd(`LCP_ADDR_FLAG, 32'h0, 1'b0);
        sel(4'h0, 5);
        chk(edge_irq_flag, 1'b0, "fall masked");
        // the rise reaches the flag at the same edge as the clear
        sel(4'hf, 1);
        wr(`LCP_ADDR_FLAG, 32'h1);
        wt(1);
        chk(edge_irq_flag, 1'b1, "set beats clear");
        wr(`LCP_ADDR_FLAG, 32'h1);
        sel(4'h0, 5);
        chk(edge_irq_flag, 1'b0, "flag cleared");
        wr(`LCP_ADDR_CTRL, 32'h8a);
        sel(4'hf, 5);
        chk(edge_irq_flag, 1'b0, "rise masked");
        sel(4'h0, 5);
        chk(edge_irq_flag, 1'b1, "fall flag");
        wr(`LCP_ADDR_FLAG, 32'h1);
        wr(`LCP_ADDR_POL, 32'h80);
        wt(3);
        chk(edge_irq_flag, 1'b0, "invert rise masked");
        wr(`LCP_ADDR_POL, 32'h05);
        wt(3);
        chk(edge_irq_flag, 1'b1, "invert fall flag");
        $display("test flag done");

        wr(`LCP_ADDR_CTRL, 32'hca);
        @(posedge pclk);
        presetn <= 1'b0;
        wt(2);
        presetn <= 1'b1;
        chk(pin_oe, 1'b0, "oe in reset");
        rd(`LCP_ADDR_CTRL, 32'h0, 1'b0);
        rd(`LCP_ADDR_POL, 32'h05, 1'b0);
        rd(`LCP_ADDR_FLAG, 32'h0, 1'b0);
        $display("test second reset done");
        print_verdict();
    end

endmodule : lcp_top_tb
